/* File: apm_pkg.sv */
// apm_pkg: register map, field layout and flag codes of the gain-control pin multiplexer
// assumes byte addressing on a 32-bit avalon-mm slave, one register per aligned word
package apm_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int APM_PINS = 4;
    localparam int APM_FLAG_PINS = 2;
    localparam int APM_ADDR_W = 12;
    localparam int APM_DATA_W = 32;
    localparam int APM_REG_W = 8;
    localparam int APM_SEL_W = 3;

    // ************************************************************
    // register indices and byte addresses (byte address is four times the index)
    // ************************************************************
    localparam logic [APM_ADDR_W-1:0] APM_IDX_PIN3_SEL = 12'h19B;
    localparam logic [APM_ADDR_W-1:0] APM_IDX_PIN4_SEL = 12'h19C;
    localparam logic [APM_ADDR_W-1:0] APM_IDX_FLAG_EN = 12'h19E;
    localparam logic [APM_ADDR_W-1:0] APM_IDX_OVR_MASK = 12'h1B0;
    localparam logic [APM_ADDR_W-1:0] APM_IDX_OVR_DIR = 12'h1B1;
    localparam logic [APM_ADDR_W-1:0] APM_IDX_OVR_LEVEL = 12'h1B2;
    localparam logic [APM_ADDR_W-1:0] APM_IDX_OUT_STATUS = 12'h1B3;
    localparam logic [APM_ADDR_W-1:0] APM_IDX_IN_STATUS = 12'h1B4;
    localparam logic [APM_ADDR_W-1:0] APM_ADDR_PIN3_SEL = APM_IDX_PIN3_SEL << 2;
    localparam logic [APM_ADDR_W-1:0] APM_ADDR_PIN4_SEL = APM_IDX_PIN4_SEL << 2;
    localparam logic [APM_ADDR_W-1:0] APM_ADDR_FLAG_EN = APM_IDX_FLAG_EN << 2;
    localparam logic [APM_ADDR_W-1:0] APM_ADDR_OVR_MASK = APM_IDX_OVR_MASK << 2;
    localparam logic [APM_ADDR_W-1:0] APM_ADDR_OVR_DIR = APM_IDX_OVR_DIR << 2;
    localparam logic [APM_ADDR_W-1:0] APM_ADDR_OVR_LEVEL = APM_IDX_OVR_LEVEL << 2;
    localparam logic [APM_ADDR_W-1:0] APM_ADDR_OUT_STATUS = APM_IDX_OUT_STATUS << 2;
    localparam logic [APM_ADDR_W-1:0] APM_ADDR_IN_STATUS = APM_IDX_IN_STATUS << 2;

    // ************************************************************
    // fields and reset values
    // ************************************************************
    localparam int APM_EN_PIN3_BIT = 0;
    localparam int APM_EN_PIN4_BIT = 1;
    localparam int APM_EN_OR_BIT = 4;
    localparam logic [APM_REG_W-1:0] APM_RST_REG = 8'h00;
    localparam logic [APM_SEL_W-1:0] APM_RST_SEL = 3'h0;

    // ************************************************************
    // flag source codes
    // ************************************************************
    typedef enum logic [APM_SEL_W-1:0] {
        APM_CODE_ADC_RESET = 3'h0,
        APM_CODE_PEAK_THR0 = 3'h4,
        APM_CODE_PEAK_THR1 = 3'h5,
        APM_CODE_BELOW_LOW = 3'h6
    } apm_flag_code_type;

endpackage

/* File: apm_flag_select.sv */
// apm_flag_select: picks one detector flag for a flag pin
// assumes detector flags are synchronous single-bit levels or pulses
`timescale 1ns/100ps

module apm_flag_select (
    input wire logic [apm_pkg::APM_SEL_W-1:0] sel,
    input wire logic enable,
    input wire logic combine,
    input wire logic adc_reset,
    input wire logic peak_thr0,
    input wire logic peak_thr1,
    input wire logic below_low,
    output logic flag
);

    // ************************************************************
    // source choice
    // ************************************************************
    logic peak_pick;
    logic peak_code;

    // peak and below-low flags; every other code, the plain reset source included, clears peak_code
    always_comb begin
        peak_pick = 1'b0;
        peak_code = 1'b1;
        case (sel)
            apm_pkg::APM_CODE_PEAK_THR0: peak_pick = peak_thr0;
            apm_pkg::APM_CODE_PEAK_THR1: peak_pick = peak_thr1;
            apm_pkg::APM_CODE_BELOW_LOW: peak_pick = below_low;
            default: peak_code = 1'b0;
        endcase
    end

    // disabled pin is forced low; unlisted codes give low
    always_comb begin
        flag = 1'b0;
        if (!enable) begin
            flag = 1'b0;
        end else if (sel == apm_pkg::APM_CODE_ADC_RESET) begin
            flag = adc_reset;
        end else if (peak_code) begin
            flag = peak_pick | (combine & adc_reset);
        end else begin
            flag = 1'b0;
        end
    end

endmodule // apm_flag_select

/* File: apm_pin_mux.sv */
// apm_pin_mux: register file and output multiplexer for four gain-control pins
// assumes synchronous pin inputs, an avalon-mm master on the same clock, byte addresses
`timescale 1ns/100ps

// Contract
// - pin 4 code 000 gives reset pulse
// - codes 100/101 give peak threshold flags
// - code 110 gives below-low dwell flag
// - pin 3 has own select, same codes
// - combine bit ORs reset into peak flags
// - enable bit 1 low holds pin 4 low
// - enable bit 0 low holds pin 3 low
// - override mask makes pin general purpose
// - mask bits 0..3 map pins 1..4
// - direction bit 1 output, 0 input
// - direction ignored without override
// - override output drives programmed level bit
// - sampled input pins readable by software
module apm_pin_mux (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [apm_pkg::APM_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [apm_pkg::APM_DATA_W-1:0] avs_writedata,
    output logic [apm_pkg::APM_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic adc_reset_pulse,
    input wire logic peak_above_thr0,
    input wire logic peak_above_thr1,
    input wire logic peak_below_low,
    input wire logic [1:0] other_fn_out,
    input wire logic [1:0] other_fn_oe,
    input wire logic [apm_pkg::APM_PINS-1:0] control_pin_in,
    output logic [apm_pkg::APM_PINS-1:0] control_pin_out,
    output logic [apm_pkg::APM_PINS-1:0] control_pin_oe
);

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta_n_reg;
    logic rst_n_reg;

    // async assert, two-flop release so every register leaves reset on the same edge
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_n_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_n_reg <= 1'b1;
            rst_n_reg <= rst_meta_n_reg;
        end
    end

    // ************************************************************
    // bus slave
    // ************************************************************
    logic ack_reg;
    logic bus_req;
    logic wr_take;
    logic [apm_pkg::APM_REG_W-1:0] wr_byte;
    logic [apm_pkg::APM_REG_W-1:0] rd_byte;
    logic [apm_pkg::APM_DATA_W-1:0] readdata_reg;

    // every access waits exactly one cycle; keeps read data a clean flop output
    assign bus_req = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack_reg;
    assign wr_take = avs_write & ack_reg & avs_byteenable[0];
    assign wr_byte = avs_writedata[apm_pkg::APM_REG_W-1:0];

    // one-cycle acknowledge per request
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    logic [apm_pkg::APM_SEL_W-1:0] sel_reg [apm_pkg::APM_FLAG_PINS];
    logic en_or_reg;
    logic [apm_pkg::APM_FLAG_PINS-1:0] flag_en_reg;
    logic [apm_pkg::APM_PINS-1:0] ovr_mask_reg;
    logic [apm_pkg::APM_PINS-1:0] ovr_dir_reg;
    logic [apm_pkg::APM_PINS-1:0] ovr_level_reg;

    // flag source selects; reserved bits are not stored and read zero
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            sel_reg[0] <= apm_pkg::APM_RST_SEL;
            sel_reg[1] <= apm_pkg::APM_RST_SEL;
        end else if (wr_take) begin
            if (avs_address == apm_pkg::APM_ADDR_PIN3_SEL) begin
                sel_reg[0] <= wr_byte[apm_pkg::APM_SEL_W-1:0];
            end
            if (avs_address == apm_pkg::APM_ADDR_PIN4_SEL) begin
                sel_reg[1] <= wr_byte[apm_pkg::APM_SEL_W-1:0];
            end
        end
    end

    // flag enables and combine bit
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            flag_en_reg <= apm_pkg::APM_RST_REG[apm_pkg::APM_FLAG_PINS-1:0];
            en_or_reg <= apm_pkg::APM_RST_REG[apm_pkg::APM_EN_OR_BIT];
        end else if (wr_take && avs_address == apm_pkg::APM_ADDR_FLAG_EN) begin
            flag_en_reg[0] <= wr_byte[apm_pkg::APM_EN_PIN3_BIT];
            flag_en_reg[1] <= wr_byte[apm_pkg::APM_EN_PIN4_BIT];
            en_or_reg <= wr_byte[apm_pkg::APM_EN_OR_BIT];
        end
    end

    // override mask, direction and drive level
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ovr_mask_reg <= apm_pkg::APM_RST_REG[apm_pkg::APM_PINS-1:0];
            ovr_dir_reg <= apm_pkg::APM_RST_REG[apm_pkg::APM_PINS-1:0];
            ovr_level_reg <= apm_pkg::APM_RST_REG[apm_pkg::APM_PINS-1:0];
        end else if (wr_take) begin
            if (avs_address == apm_pkg::APM_ADDR_OVR_MASK) begin
                ovr_mask_reg <= wr_byte[apm_pkg::APM_PINS-1:0];
            end
            if (avs_address == apm_pkg::APM_ADDR_OVR_DIR) begin
                ovr_dir_reg <= wr_byte[apm_pkg::APM_PINS-1:0];
            end
            if (avs_address == apm_pkg::APM_ADDR_OVR_LEVEL) begin
                ovr_level_reg <= wr_byte[apm_pkg::APM_PINS-1:0];
            end
        end
    end

    // ************************************************************
    // pin sampling and status
    // ************************************************************
    logic [apm_pkg::APM_PINS-1:0] pin_sample_reg;
    logic [apm_pkg::APM_PINS-1:0] in_status;
    logic [apm_pkg::APM_PINS-1:0] out_status;

    // inputs are synchronous, so one flop is enough
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pin_sample_reg <= apm_pkg::APM_RST_REG[apm_pkg::APM_PINS-1:0];
        end else begin
            pin_sample_reg <= control_pin_in;
        end
    end

    // only override inputs show in readback; only override outputs in output status
    assign in_status = pin_sample_reg & ovr_mask_reg & ~ovr_dir_reg;
    assign out_status = control_pin_out & ovr_mask_reg & ovr_dir_reg;

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_byte = apm_pkg::APM_RST_REG;
        unique case (avs_address)
            apm_pkg::APM_ADDR_PIN3_SEL: rd_byte[apm_pkg::APM_SEL_W-1:0] = sel_reg[0];
            apm_pkg::APM_ADDR_PIN4_SEL: rd_byte[apm_pkg::APM_SEL_W-1:0] = sel_reg[1];
            apm_pkg::APM_ADDR_FLAG_EN: begin
                rd_byte[apm_pkg::APM_EN_PIN3_BIT] = flag_en_reg[0];
                rd_byte[apm_pkg::APM_EN_PIN4_BIT] = flag_en_reg[1];
                rd_byte[apm_pkg::APM_EN_OR_BIT] = en_or_reg;
            end
            apm_pkg::APM_ADDR_OVR_MASK: rd_byte[apm_pkg::APM_PINS-1:0] = ovr_mask_reg;
            apm_pkg::APM_ADDR_OVR_DIR: rd_byte[apm_pkg::APM_PINS-1:0] = ovr_dir_reg;
            apm_pkg::APM_ADDR_OVR_LEVEL: rd_byte[apm_pkg::APM_PINS-1:0] = ovr_level_reg;
            apm_pkg::APM_ADDR_OUT_STATUS: rd_byte[apm_pkg::APM_PINS-1:0] = out_status;
            apm_pkg::APM_ADDR_IN_STATUS: rd_byte[apm_pkg::APM_PINS-1:0] = in_status;
            default: rd_byte = apm_pkg::APM_RST_REG;
        endcase
    end

    // read data captured in the wait cycle, held through the answer cycle
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            readdata_reg <= '0;
        end else if (avs_read && !ack_reg) begin
            readdata_reg <= {{(apm_pkg::APM_DATA_W-apm_pkg::APM_REG_W){1'b0}}, rd_byte};
        end
    end
    assign avs_readdata = readdata_reg;

    // ************************************************************
    // pin multiplexer
    // ************************************************************
    logic [apm_pkg::APM_PINS-1:0] pin_out_next;
    logic [apm_pkg::APM_PINS-1:0] pin_oe_next;
    logic [apm_pkg::APM_PINS-1:0] pin_out_reg;
    logic [apm_pkg::APM_PINS-1:0] pin_oe_reg;

    genvar gi;
    generate
        for (gi = 0; gi < apm_pkg::APM_PINS; gi++) begin : g_pin
            logic func_out;
            logic func_oe;
            if (gi >= apm_pkg::APM_PINS - apm_pkg::APM_FLAG_PINS) begin : g_flag
                // flag pins are driven unless overridden; enable low means a held low
                apm_flag_select apm_flag_select_i (
                    .sel(sel_reg[gi-2]),
                    .enable(flag_en_reg[gi-2]),
                    .combine(en_or_reg),
                    .adc_reset(adc_reset_pulse),
                    .peak_thr0(peak_above_thr0),
                    .peak_thr1(peak_above_thr1),
                    .below_low(peak_below_low),
                    .flag(func_out)
                );
                assign func_oe = 1'b1;
            end else begin : g_other
                // pins 1 and 2 carry the attenuator port unless overridden
                assign func_out = other_fn_out[gi];
                assign func_oe = other_fn_oe[gi];
            end
            // override beats any assigned function; direction only counts under override
            assign pin_oe_next[gi] = ovr_mask_reg[gi] ? ovr_dir_reg[gi] : func_oe;
            assign pin_out_next[gi] = ovr_mask_reg[gi] ? (ovr_dir_reg[gi] & ovr_level_reg[gi]) : func_out;
        end
    endgenerate

    // pins leave from flops, one cycle behind the selected source
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pin_out_reg <= '0;
            pin_oe_reg <= '0;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
        end
    end
    assign control_pin_out = pin_out_reg;
    assign control_pin_oe = pin_oe_reg;

    // ************************************************************
    // checks
    // ************************************************************
    logic [1:0] chk_live_reg;

    // checks wait two edges after release: pins still show reset values on the first one
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            chk_live_reg <= 2'h0;
        end else begin
            chk_live_reg <= {chk_live_reg[0], 1'b1};
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!chk_live_reg[1]);

    sequence req_waits;
        bus_req && avs_waitrequest;
    endsequence
    sequence req_answered;
        bus_req && !avs_waitrequest;
    endsequence

    bus_answer_a: assert property (req_waits ##1 bus_req |-> req_answered)
        else $error("bus request not answered after one wait cycle");

    pin4_reset_a: assert property ($past(!ovr_mask_reg[3] && flag_en_reg[1] && sel_reg[1] == 3'h0)
        |-> control_pin_out[3] == $past(adc_reset_pulse))
        else $error("pin 4 does not follow reset pulse");

    peak_route_a: assert property ($past(!ovr_mask_reg[3] && flag_en_reg[1] && !en_or_reg
        && sel_reg[1] == 3'h5) |-> control_pin_out[3] == $past(peak_above_thr1))
        else $error("pin 4 does not follow second threshold flag");

    dwell_route_a: assert property ($past(!ovr_mask_reg[3] && flag_en_reg[1] && !en_or_reg
        && sel_reg[1] == 3'h6) |-> control_pin_out[3] == $past(peak_below_low))
        else $error("pin 4 does not follow below-low flag");

    pin3_route_a: assert property ($past(!ovr_mask_reg[2] && flag_en_reg[0] && !en_or_reg
        && sel_reg[0] == 3'h4) |-> control_pin_out[2] == $past(peak_above_thr0))
        else $error("pin 3 does not follow first threshold flag");

    combine_or_a: assert property ($past(!ovr_mask_reg[2] && flag_en_reg[0] && en_or_reg
        && sel_reg[0] == 3'h4 && adc_reset_pulse) |-> control_pin_out[2] && control_pin_oe[2])
        else $error("combined reset pulse missing on pin 3");

    pin4_held_a: assert property ($past(!ovr_mask_reg[3] && !flag_en_reg[1])
        |-> !control_pin_out[3] && control_pin_oe[3])
        else $error("disabled pin 4 not driven low");

    pin3_held_a: assert property ($past(!ovr_mask_reg[2] && !flag_en_reg[0])
        |-> !control_pin_out[2] && control_pin_oe[2])
        else $error("disabled pin 3 not driven low");

    override_pin1_a: assert property ($past(ovr_mask_reg[0] && ovr_dir_reg[0])
        |-> control_pin_oe[0] && control_pin_out[0] == $past(ovr_level_reg[0]))
        else $error("pin 1 override output wrong");

    override_wins_a: assert property ($past(ovr_mask_reg[3] && ovr_dir_reg[3] && flag_en_reg[1])
        |-> control_pin_out[3] == $past(ovr_level_reg[3]))
        else $error("flag not overridden on pin 4");

    input_float_a: assert property ($past(ovr_mask_reg[1] && !ovr_dir_reg[1]) |-> !control_pin_oe[1])
        else $error("override input pin still driven");

    dir_ignored_a: assert property ($past(!ovr_mask_reg[2] && !ovr_dir_reg[2]) |-> control_pin_oe[2])
        else $error("direction applied without override");

    level_drive_a: assert property ($past(ovr_mask_reg[2] && ovr_dir_reg[2])
        |-> control_pin_out[2] == $past(ovr_level_reg[2]))
        else $error("override level not driven on pin 3");

    readback_a: assert property (ovr_mask_reg[0] && !ovr_dir_reg[0]
        |-> in_status[0] == $past(control_pin_in[0]))
        else $error("input readback does not match pin");

    unlisted_low_a: assert property ($past(!ovr_mask_reg[3] && flag_en_reg[1]
        && (sel_reg[1] == 3'h1 || sel_reg[1] == 3'h7)) |-> !control_pin_out[3])
        else $error("unlisted code does not drive low");

endmodule // apm_pin_mux

/* File: apm_far_model.sv */
// apm_far_model: external gain controller logic sitting on the four control pins
// assumes the same clock as the multiplexer; the bench sets what this side drives
`timescale 1ns/100ps

module apm_far_model (
    input wire logic clock,
    input wire logic [3:0] dev_out,
    input wire logic [3:0] dev_oe,
    input wire logic [3:0] far_val,
    input wire logic [3:0] far_oe,
    output logic [3:0] pin_level
);
    // ************************************************************
    // pin resolution
    // ************************************************************
    logic [3:0] float_reg;

    // pins that nobody drives keep changing, so a stale level never passes for a driven one
    always_ff @(posedge clock) begin
        float_reg <= (float_reg === 4'h5) ? 4'hA : 4'h5;
    end

    // the device wins where it drives; this side drives only pins that are left free
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_level[i] = dev_oe[i] ? dev_out[i] : (far_oe[i] ? far_val[i] : float_reg[i]);
        end
    end
endmodule // apm_far_model

/* File: apm_pin_mux_tb.sv */
// apm_pin_mux_tb: register bus and pin checks of the gain-control pin multiplexer
// assumes apm_pkg, apm_pin_mux and apm_far_model are compiled ahead of it
`timescale 1ns/100ps

module apm_pin_mux_tb;
    logic clock, arst_n, avs_read, avs_write, avs_waitrequest;
    logic [apm_pkg::APM_ADDR_W-1:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic adc_reset_pulse, peak_above_thr0, peak_above_thr1, peak_below_low;
    logic [1:0] other_fn_out, other_fn_oe;
    logic [3:0] control_pin_in, control_pin_out, control_pin_oe, far_val, far_oe;
    logic [7:0] sel3, sel4, en, mask, dir, lvl;
    logic [11:0] addrs [8];
    logic [7:0] wmask [6];
    int n_errors, n_tests;

    apm_pin_mux apm_pin_mux_i (.clock(clock), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .adc_reset_pulse(adc_reset_pulse), .peak_above_thr0(peak_above_thr0),
        .peak_above_thr1(peak_above_thr1), .peak_below_low(peak_below_low), .other_fn_out(other_fn_out),
        .other_fn_oe(other_fn_oe), .control_pin_in(control_pin_in), .control_pin_out(control_pin_out),
        .control_pin_oe(control_pin_oe));
    apm_far_model apm_far_model_i (.clock(clock), .dev_out(control_pin_out), .dev_oe(control_pin_oe),
        .far_val(far_val), .far_oe(far_oe), .pin_level(control_pin_in));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic end_of_test;
        if (n_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one bus cycle; request held until waitrequest is seen low at a rising edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic be0);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= {3'h7, be0};
        avs_write <= wr;
        avs_read <= ~wr;
        // waitrequest is only looked at on rising edges, where the slave takes the request
        do begin
            @(posedge clock);
            n++;
            if (n > 20) begin
                n_errors++;
                $display("BAD %0t bus answer missing", $time);
                end_of_test;
            end
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // shadow copy keeps only the bits a register really has
        if (wr && be0) begin
            case (a)
                apm_pkg::APM_ADDR_PIN3_SEL: sel3 = d & 8'h07;
                apm_pkg::APM_ADDR_PIN4_SEL: sel4 = d & 8'h07;
                apm_pkg::APM_ADDR_FLAG_EN: en = d & 8'h13;
                apm_pkg::APM_ADDR_OVR_MASK: mask = d & 8'h0F;
                apm_pkg::APM_ADDR_OVR_DIR: dir = d & 8'h0F;
                apm_pkg::APM_ADDR_OVR_LEVEL: lvl = d & 8'h0F;
                default: ;
            endcase
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, 1'b1);
    endtask

    task automatic rd_check(input logic [11:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00, 1'b1);
        check(q, {24'h000000, e});
    endtask

    // f: bit0 reset pulse, bit1 threshold 0, bit2 threshold 1, bit3 below low
    function automatic logic flag_of(input logic [2:0] s, input logic [3:0] f);
        logic c;
        c = en[4] & f[0];
        case (s)
            3'h0: return f[0];
            3'h4: return f[1] | c;
            3'h5: return f[2] | c;
            3'h6: return f[3] | c;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [7:0] exp_pins(input logic [3:0] f);
        logic [3:0] o, e;
        e = {2'h3, f[3:2]};
        o = {en[1] & flag_of(sel4[2:0], f), en[0] & flag_of(sel3[2:0], f), f[1:0]};
        for (int i = 0; i < 4; i++) begin
            if (mask[i]) begin
                e[i] = dir[i];
                o[i] = dir[i] & lvl[i];
            end
        end
        return {e, o};
    endfunction

    // drive flags and normal functions, then compare pins one edge later
    task automatic check_pins(input logic [3:0] f);
        logic [7:0] e;
        @(posedge clock);
        {peak_below_low, peak_above_thr1, peak_above_thr0, adc_reset_pulse} <= f;
        other_fn_out <= f[1:0];
        other_fn_oe <= f[3:2];
        @(posedge clock);
        #1;
        e = exp_pins(f);
        check({28'h0, control_pin_oe}, {28'h0, e[7:4]});
        check({28'h0, control_pin_out & e[7:4]}, {28'h0, e[3:0] & e[7:4]});
    endtask

    task automatic do_reset;
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (8) @(posedge clock);
        #1;
        check({24'h0, control_pin_oe, control_pin_out}, 32'h0);
        @(posedge clock);
        arst_n <= 1'b1;
        {sel3, sel4, en, mask, dir, lvl} = 48'h0;
        repeat (3) @(posedge clock);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial begin
        {arst_n, avs_read, avs_write, adc_reset_pulse, peak_above_thr0, peak_above_thr1, peak_below_low} = 7'h0;
        {avs_address, avs_byteenable, avs_writedata} = 48'h0;
        {other_fn_out, other_fn_oe, far_val, far_oe} = 12'h0;
        n_errors = 0;
        n_tests = 0;
        addrs = '{apm_pkg::APM_ADDR_PIN3_SEL, apm_pkg::APM_ADDR_PIN4_SEL, apm_pkg::APM_ADDR_FLAG_EN,
            apm_pkg::APM_ADDR_OVR_MASK, apm_pkg::APM_ADDR_OVR_DIR, apm_pkg::APM_ADDR_OVR_LEVEL,
            apm_pkg::APM_ADDR_OUT_STATUS, apm_pkg::APM_ADDR_IN_STATUS};
        wmask = '{8'h07, 8'h07, 8'h13, 8'h0F, 8'h0F, 8'h0F};
        do_reset;
        // reset values, then status stays read-only and reserved bits read zero
        for (int i = 0; i < 8; i++) rd_check(addrs[i], 8'h00);
        for (int i = 6; i < 8; i++) begin
            wr(addrs[i], 8'hFF);
            rd_check(addrs[i], 8'h00);
        end
        for (int i = 0; i < 6; i++) wr(addrs[i], 8'hFF);
        for (int i = 0; i < 6; i++) rd_check(addrs[i], wmask[i]);
        rd_check(apm_pkg::APM_ADDR_OUT_STATUS, 8'h0F);
        xfer(1'b1, apm_pkg::APM_ADDR_OVR_MASK, 8'h00, 1'b0);
        rd_check(apm_pkg::APM_ADDR_OVR_MASK, 8'h0F);
        wr(12'h004, 8'hFF);
        rd_check(12'h004, 8'h00);
        // reset in mid-run clears everything again
        do_reset;
        for (int i = 0; i < 6; i++) rd_check(addrs[i], 8'h00);
        // every code on both flag pins, with both enables off, both on, and both on with combine
        for (int k = 0; k < 3; k++) begin
            wr(apm_pkg::APM_ADDR_FLAG_EN, (k == 0) ? 8'h00 : ((k == 1) ? 8'h03 : 8'h13));
            for (int s = 0; s < 8; s++) begin
                wr(apm_pkg::APM_ADDR_PIN3_SEL, 8'(s));
                wr(apm_pkg::APM_ADDR_PIN4_SEL, 8'(7 - s));
                for (int f = 0; f < 16; f++) check_pins(4'(f));
            end
        end
        // every override pattern over a mixed direction and level
        wr(apm_pkg::APM_ADDR_PIN3_SEL, 8'h00);
        wr(apm_pkg::APM_ADDR_PIN4_SEL, 8'h00);
        wr(apm_pkg::APM_ADDR_OVR_DIR, 8'h05);
        wr(apm_pkg::APM_ADDR_OVR_LEVEL, 8'h09);
        for (int m = 0; m < 16; m++) begin
            wr(apm_pkg::APM_ADDR_OVR_MASK, 8'(m));
            check_pins(4'hF);
            check_pins(4'h0);
        end
        // far side drives the input pins; software reads them back
        @(posedge clock);
        far_oe <= 4'hF;
        for (int d = 0; d < 2; d++) begin
            wr(apm_pkg::APM_ADDR_OVR_DIR, (d == 0) ? 8'h03 : 8'h0C);
            @(posedge clock);
            far_val <= (d == 0) ? 4'h8 : 4'h2;
            check_pins(4'h0);
            rd_check(apm_pkg::APM_ADDR_IN_STATUS, {4'h0, far_val & ~dir[3:0]});
            rd_check(apm_pkg::APM_ADDR_OUT_STATUS, {4'h0, lvl[3:0] & dir[3:0]});
        end
        end_of_test;
    end
endmodule // apm_pin_mux_tb
